// File: design/otp_wiper_regs.svh
// Purpose: constants for the fuse-backed wiper setting control
// Assumes: 100 MHz clock, 10 ns period
// Notes: fuse burn time is counted in clock cycles
`ifndef OTP_WIPER_REGS_SVH
`define OTP_WIPER_REGS_SVH
`define WIPER_MIDSCALE 8'h80
`define WIPER_RESET_CODE 8'h80
`define CLK_PERIOD_NS 10
`define FUSE_BURN_MS 400
`define FUSE_BURN_CYCLES ((`FUSE_BURN_MS * 1000000) / `CLK_PERIOD_NS)
`endif

// File: design/otp_wiper_pkg.sv
// Purpose: types for the fuse-backed wiper setting control
// Assumes: nothing
// Notes: state is one packed struct
package otp_wiper_pkg;
  typedef enum logic [3:0] {
    ST_LOAD = 4'h1,
    ST_RUN = 4'h2,
    ST_BURN = 4'h4,
    ST_DONE = 4'h8
  } ctl_state_type;

  typedef struct packed {
    logic fuse_status_high;
    logic fuse_status_low;
  } status_type;

  typedef struct packed {
    ctl_state_type state;
    logic [7:0] wiper;
    logic [31:0] burn_cnt;
    logic burn_req;
    logic [7:0] burn_code;
    status_type status;
    logic burn_used;
  } ctl_type;
endpackage

// File: design/tap_decoder.sv
// Purpose: decode the wiper code into one of 256 tap selects
// Assumes: code is registered upstream
// Notes: select comes out of a register
`timescale 1ns/1ps
`include "otp_wiper_regs.svh"
module tap_decoder import otp_wiper_pkg::*; #(
  parameter int TAPS = 256
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [$clog2(TAPS)-1:0] i_code,
  output logic [TAPS-1:0] o_tap_sel
);
  localparam int CW = $clog2(TAPS);
  if (TAPS != 256) begin : g_bad_taps
    $error("tap_decoder serves 256 taps only");
  end
  logic [TAPS-1:0] sel_reg;
  logic [TAPS-1:0] sel_next;
  // ==========================================================
  // one bit per tap, code zero is the b end
  genvar g;
  generate
    for (g = 0; g < TAPS; g++) begin : g_tap
      assign sel_next[g] = (i_code == CW'(g)); // [RL8] [RL9]
    end
  endgenerate
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sel_reg <= TAPS'(1) << `WIPER_RESET_CODE;
    end else begin
      sel_reg <= sel_next;
    end
  end
  assign o_tap_sel = sel_reg;
  // ==========================================================
  // checks
  property p_tap_one_hot;
    @(posedge i_clk) disable iff (i_rst) $onehot(o_tap_sel);
  endproperty
  a_tap_one_hot: assert property (p_tap_one_hot) else $error("tap select not one-hot"); // [RL8]
  property p_tap_match;
    @(posedge i_clk) disable iff (i_rst)
      !$past(i_rst) |-> o_tap_sel == (TAPS'(1) << $past(i_code));
  endproperty
  a_tap_match: assert property (p_tap_match) else $error("tap select off code"); // [RL9]
endmodule

// File: design/otp_wiper_ctl.sv
// Summary of operation
// RL1 - unprogrammed fuses: wiper loads midscale 128 at every power-on
// RL2 - programmed fuses: wiper comes up at the stored setting
// RL3 - programming request bit with valid command burns current wiper into fuses
// RL4 - two readable validation bits report programming status
// RL5 - controller should read validation bits after each programming attempt
// RL6 - controller issues fuse burn only once; retries are not reliable
// RL7 - after burn, fuse latches are enabled at every later power-on
// RL8 - 8-bit wiper code decodes to exactly one of 256 taps
// RL9 - code zero is the b terminal; each increment one tap up
// RL10 - burn takes about 400 ms before status is meaningful
// RL11 - after programming, wiper writes still act until next power-on
// RL12 - before programming, wiper writes are unlimited and immediate
//
// Purpose: wiper latch, power-on preset and fuse programming control
// Assumes: i_rst is the power-on reset; fuses live outside as plain pins
// Notes: fuse array is read through i_fuse_*, burned through o_fuse_*
`timescale 1ns/1ps
`include "otp_wiper_regs.svh"
module otp_wiper_ctl import otp_wiper_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int BURN_CYCLES = `FUSE_BURN_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_code,
  input wire logic i_prog_req,
  input wire logic i_fuse_blown,
  input wire logic [WIDTH-1:0] i_fuse_code,
  input wire logic i_fuse_ok,
  output logic [WIDTH-1:0] o_wiper_code_latch,
  output logic o_fuse_status_high,
  output logic o_fuse_status_low,
  output logic o_fuse_burn,
  output logic [WIDTH-1:0] o_fuse_burn_code,
  output logic o_busy,
  output logic [(1<<WIDTH)-1:0] o_tap_sel
);
  if (WIDTH != 8) begin : g_bad_width
    $error("wiper width must be 8");
  end
  if (BURN_CYCLES < 1) begin : g_bad_burn
    $error("burn count must be positive");
  end

  ctl_type st_reg;
  ctl_type st_next;

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.state)
      ST_LOAD: begin
        // fuse latches enabled once at power-up
        if (i_fuse_blown) begin
          st_next.wiper = i_fuse_code; // [RL2] [RL7]
          st_next.status = '{fuse_status_high: 1'b1, fuse_status_low: i_fuse_ok}; // [RL4]
          st_next.burn_used = 1'b1;
        end else begin
          st_next.wiper = `WIPER_MIDSCALE; // [RL1]
        end
        st_next.state = ST_RUN;
      end
      ST_RUN: begin
        if (i_wr_valid) begin
          st_next.wiper = i_wr_code; // [RL11] [RL12]
        end
        if (i_prog_req && !st_reg.burn_used) begin
          st_next.burn_code = i_wr_valid ? i_wr_code : st_reg.wiper; // [RL3]
          st_next.burn_req = 1'b1;
          st_next.burn_cnt = 32'(BURN_CYCLES - 1);
          st_next.burn_used = 1'b1; // [RL6]
          st_next.state = ST_BURN;
        end
      end
      ST_BURN: begin
        if (i_wr_valid) begin
          st_next.wiper = i_wr_code;
        end
        if (st_reg.burn_cnt == 32'h0) begin
          st_next.burn_req = 1'b0; // [RL10]
          st_next.status = '{fuse_status_high: 1'b1, fuse_status_low: i_fuse_ok}; // [RL4] [RL5]
          st_next.state = ST_DONE;
        end else begin
          st_next.burn_cnt = st_reg.burn_cnt - 32'h1;
        end
      end
      ST_DONE: begin
        if (i_wr_valid) begin
          st_next.wiper = i_wr_code; // [RL11]
        end
      end
      default: st_next.state = ST_LOAD;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg.state <= ST_LOAD;
      st_reg.wiper <= `WIPER_RESET_CODE;
      st_reg.burn_cnt <= 32'h0;
      st_reg.burn_req <= 1'b0;
      st_reg.burn_code <= 8'h00;
      st_reg.status <= '0;
      st_reg.burn_used <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign o_wiper_code_latch = st_reg.wiper;
  assign o_fuse_status_high = st_reg.status.fuse_status_high;
  assign o_fuse_status_low = st_reg.status.fuse_status_low;
  assign o_fuse_burn = st_reg.burn_req;
  assign o_fuse_burn_code = st_reg.burn_code;
  // burn request flop is high exactly while burning
  assign o_busy = st_reg.burn_req;

  tap_decoder #(
    .TAPS(1 << WIDTH)
  ) u_tap (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_code(st_reg.wiper),
    .o_tap_sel(o_tap_sel)
  );

  // ==========================================================
  // checks
  property p_mid_preset;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_LOAD && !i_fuse_blown) |=> o_wiper_code_latch == `WIPER_MIDSCALE;
  endproperty
  a_mid_preset: assert property (p_mid_preset) else $error("no midscale preset"); // [RL1]

  property p_fuse_load;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_LOAD && i_fuse_blown) |=>
        (o_wiper_code_latch == $past(i_fuse_code) && o_fuse_status_high);
  endproperty
  a_fuse_load: assert property (p_fuse_load) else $error("stored setting not loaded"); // [RL2]

  property p_burn_start;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_RUN && i_prog_req && !st_reg.burn_used && !i_wr_valid) |=>
        (o_fuse_burn && o_fuse_burn_code == $past(o_wiper_code_latch));
  endproperty
  a_burn_start: assert property (p_burn_start) else $error("burn not started"); // [RL3]

  property p_status_after;
    @(posedge i_clk) disable iff (i_rst)
      $fell(o_fuse_burn) |-> o_fuse_status_high && o_fuse_status_low == $past(i_fuse_ok);
  endproperty
  a_status_after: assert property (p_status_after) else $error("status not reported"); // [RL4]

  property p_once;
    @(posedge i_clk) disable iff (i_rst)
      st_reg.burn_used |=> !$rose(o_fuse_burn);
  endproperty
  a_once: assert property (p_once) else $error("second burn issued"); // [RL6]

  property p_burn_len;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_BURN) |-> st_reg.burn_cnt < 32'(BURN_CYCLES);
  endproperty
  a_burn_len: assert property (p_burn_len) else $error("burn count out of range"); // [RL10]

  property p_write_done;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_DONE && i_wr_valid) |=> o_wiper_code_latch == $past(i_wr_code);
  endproperty
  a_write_done: assert property (p_write_done) else $error("write lost after burn"); // [RL11]

  property p_write_run;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_RUN && i_wr_valid) |=> o_wiper_code_latch == $past(i_wr_code) ##1
        o_tap_sel[$past(i_wr_code, 2)];
  endproperty
  a_write_run: assert property (p_write_run) else $error("write not applied"); // [RL12]

  property p_tap_follow;
    @(posedge i_clk) disable iff (i_rst)
      !$past(i_rst) |-> $onehot(o_tap_sel) && o_tap_sel[$past(o_wiper_code_latch)];
  endproperty
  a_tap_follow: assert property (p_tap_follow) else $error("tap lags wrong"); // [RL8] [RL9]

  property p_prog_refused;
    @(posedge i_clk) disable iff (i_rst)
      (i_prog_req && st_reg.burn_used && !o_fuse_burn) |=> !o_fuse_burn;
  endproperty
  a_prog_refused: assert property (p_prog_refused) else $error("refused burn issued"); // [RL6]

  property p_status_hold;
    @(posedge i_clk) disable iff (i_rst)
      o_fuse_status_high |=> o_fuse_status_high && $stable(o_fuse_status_low);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status changed"); // [RL4]

  property p_status_clear;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_LOAD && !i_fuse_blown) |=> !o_fuse_status_high && !o_fuse_status_low;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status set early"); // [RL4]

  property p_load_once;
    @(posedge i_clk) disable iff (i_rst)
      (st_reg.state == ST_LOAD) |=> (st_reg.state == ST_RUN);
  endproperty
  a_load_once: assert property (p_load_once) else $error("load not single"); // [RL7]

  property p_burn_code_hold;
    @(posedge i_clk) disable iff (i_rst)
      o_fuse_burn |=> $stable(o_fuse_burn_code);
  endproperty
  a_burn_code_hold: assert property (p_burn_code_hold) else $error("burn code moved"); // [RL3]

  c_burn: cover property (@(posedge i_clk) disable iff (i_rst) $fell(o_fuse_burn));
  c_fuse_up: cover property (@(posedge i_clk) disable iff (i_rst)
    st_reg.state == ST_LOAD && i_fuse_blown);
  c_write: cover property (@(posedge i_clk) disable iff (i_rst)
    st_reg.state == ST_DONE && i_wr_valid);
  c_refused: cover property (@(posedge i_clk) disable iff (i_rst)
    i_prog_req && st_reg.burn_used);
endmodule

// File: tb/fuse_array_model.sv
// Purpose: behavioural fuse array on the far side of the wiper control
// Assumes: a burn is the rising edge of i_burn
// Notes: fuses survive reset; unburnt fuses read back as junk
`timescale 1ns/1ps
module fuse_array_model (
  input wire logic i_clk,
  input wire logic i_burn,
  input wire logic [7:0] i_burn_code,
  output logic o_blown,
  output logic [7:0] o_code,
  output logic o_ok
);
  logic [7:0] store_reg = 8'h5a;
  logic prev_reg = 1'b0;
  logic blown_reg = 1'b0;
  // ===========================
  // burn once, keep forever
  always @(posedge i_clk) begin
    prev_reg <= i_burn;
    if (i_burn && !prev_reg && !blown_reg) begin
      store_reg <= i_burn_code;
      blown_reg <= 1'b1;
    end
  end
  assign o_blown = blown_reg;
  assign o_code = blown_reg ? store_reg : ~store_reg;
  assign o_ok = blown_reg;
endmodule

// File: tb/test_otp_wiper_ctl.sv
// Purpose: self-checking bench for the wiper setting control
// Assumes: burn shortened to 8 cycles
// Notes: expected wiper and tap tracked in plain variables
`timescale 1ns/1ps
module test_otp_wiper_ctl import otp_wiper_pkg::*;;
  localparam int BC = 8;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr_valid = 1'b0;
  logic [7:0] i_wr_code = 8'h00;
  logic i_prog_req = 1'b0;
  logic blown, ok, burn, busy, st_hi, st_lo;
  logic [7:0] fcode, wiper, bcode;
  logic [255:0] tap;
  logic [31:0] seed = 32'h8bede822;
  logic [7:0] w1, w2, burned;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  otp_wiper_ctl #(.WIDTH(8), .BURN_CYCLES(BC)) u_otp_wiper_ctl (.i_clk(i_clk),
    .i_rst(i_rst), .i_wr_valid(i_wr_valid), .i_wr_code(i_wr_code), .i_prog_req(i_prog_req),
    .i_fuse_blown(blown), .i_fuse_code(fcode), .i_fuse_ok(ok), .o_wiper_code_latch(wiper),
    .o_fuse_status_high(st_hi), .o_fuse_status_low(st_lo), .o_fuse_burn(burn),
    .o_fuse_burn_code(bcode), .o_busy(busy), .o_tap_sel(tap));
  fuse_array_model u_fuse_array_model (.i_clk(i_clk), .i_burn(burn), .i_burn_code(bcode),
    .o_blown(blown), .o_code(fcode), .o_ok(ok));
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  // ===========================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [255:0] got, input logic [255:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task power_on(input logic [7:0] exp);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(wiper, 8'h80);
    i_rst = 1'b0;
    @(negedge i_clk);
    chk(wiper, exp);
    w1 = exp;
    w2 = exp;
  endtask
  task sweep(input int n);
    logic [31:0] r;
    for (int i = 0; i < n + 2; i++) begin
      @(negedge i_clk);
      chk(wiper, w1);
      chk(tap, 256'h1 << w2);
      w2 = w1;
      r = xs();
      i_wr_valid = (i < n);
      i_wr_code = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
      if (i < n) w1 = i_wr_code;
    end
  endtask
  task tally_and_finish();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ===========================
  // main sequence
  initial begin
    power_on(8'h80);
    chk({st_hi, st_lo}, 2'b00);
    sweep(24);
    @(negedge i_clk);
    i_prog_req = 1'b1;
    burned = w1;
    @(negedge i_clk);
    i_prog_req = 1'b0;
    chk({burn, busy, bcode}, {2'b11, burned});
    for (int k = 1; k < BC; k++) begin
      @(negedge i_clk);
      i_prog_req = (k == 2);
      chk(burn, 1'b1);
    end
    @(negedge i_clk);
    chk({burn, busy, st_hi, st_lo}, 4'b0011);
    i_prog_req = 1'b1;
    @(negedge i_clk);
    i_prog_req = 1'b0;
    @(negedge i_clk);
    chk(burn, 1'b0);
    sweep(6);
    power_on(burned);
    i_prog_req = 1'b1;
    @(negedge i_clk);
    i_prog_req = 1'b0;
    @(negedge i_clk);
    chk(burn, 1'b0);
    sweep(6);
    tally_and_finish();
  end
endmodule
